// ---- cmpif_pkg.sv ----
// Purpose: shared constants for the comparator interface register block
// Assumes: 32-bit register words on a plain strobe port
// Notes:   offsets are byte addresses
package cmpif_pkg;
   localparam int          CMPIF_AW        = 8;
   localparam int          CMPIF_WUP_W     = 10;
   // register offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_STATE       = 8'h04;
   localparam logic [7:0]  OFS_MASK_SET    = 8'h10;
   localparam logic [7:0]  OFS_MASK_CLR    = 8'h14;
   localparam logic [7:0]  OFS_MASK_VIEW   = 8'h18;
   localparam logic [7:0]  OFS_PEND        = 8'h1C;
   localparam logic [7:0]  OFS_PEND_CLR    = 8'h20;
   localparam logic [7:0]  OFS_OVERRIDE    = 8'h24;
   localparam logic [7:0]  OFS_PRESENCE    = 8'h30;
   localparam logic [7:0]  OFS_CH_SETUP    = 8'h40;
   localparam logic [7:0]  OFS_PAIR_SETUP  = 8'h44;
   // control field positions
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          CTRL_EVT_BIT    = 1;
   localparam int          CTRL_SWGO_BIT   = 4;
   localparam int          CTRL_EVGO_BIT   = 5;
   localparam int          CTRL_BYPASS_BIT = 7;
   localparam int          CTRL_WUP_LSB    = 8;
   // status and interrupt layout
   localparam int          PAIR_LSB        = 24;
   localparam int          PRES_PAIR_LSB   = 16;
   localparam int          SETUP_IRQ_LSB   = 16;
   localparam int          PSETUP_IRQ_LSB  = 4;
   // reset values
   localparam logic [31:0] RST_WORD        = 32'h0000_0000;
   localparam logic [9:0]  RST_WUP         = 10'h000;
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   // channel modes
   localparam logic [1:0]  MODE_OFF        = 2'h0;
   localparam logic [1:0]  MODE_CONT       = 2'h1;
   localparam logic [1:0]  MODE_USER       = 2'h2;
   localparam logic [1:0]  MODE_EVENT      = 2'h3;
   // interrupt selections (channel and pair share codes)
   localparam logic [1:0]  IRQ_HIGH        = 2'h0;
   localparam logic [1:0]  IRQ_LOW         = 2'h1;
   localparam logic [1:0]  IRQ_TOGGLE      = 2'h2;
   localparam logic [1:0]  IRQ_DONE        = 2'h3;
endpackage

// ---- cmpif_chan.sv ----
// Purpose: one comparator channel: startup hold-off, sampling, irq condition
// Assumes: comparator level is synchronous to clk_sys_i
// Notes:   startup count runs in system clock cycles
`timescale 1ns/1ps
`default_nettype none
module cmpif_chan
   import cmpif_pkg::*;
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   enable_i,
   input  wire logic [1:0]             mode_i,
   input  wire logic [1:0]             irq_sel_i,
   input  wire logic [CMPIF_WUP_W-1:0] startup_i,
   input  wire logic                   cmp_i,
   input  wire logic                   user_go_i,
   input  wire logic                   event_go_i,
   output logic                        warm_o,
   output logic                        take_o,
   output logic                        ready_o,
   output logic                        state_o,
   output logic                        irq_o,
   output logic                        wup_done_o
);
   logic [CMPIF_WUP_W-1:0] cnt_r;
   logic                   warm_r;
   logic                   valid_r;
   logic                   state_r;
   logic                   irq_r;
   logic                   wup_r;
   logic                   reach_w;
   logic                   hit_w;

   // hold off sampling until the startup count is reached after enable
   assign reach_w = enable_i && !warm_r && (cnt_r >= startup_i);
   assign warm_o  = warm_r;
   assign take_o  = warm_r && enable_i &&
                    ((mode_i == MODE_CONT) ||
                     (mode_i == MODE_USER && user_go_i) ||
                     (mode_i == MODE_EVENT && event_go_i));
   assign ready_o = valid_r && warm_r && enable_i;
   assign state_o = state_r;
   assign irq_o   = irq_r;
   assign wup_done_o = wup_r;

   // irq condition is judged on the sample just taken
   always_comb
   begin
      case (irq_sel_i)
         IRQ_HIGH:   hit_w = cmp_i;
         IRQ_LOW:    hit_w = !cmp_i;
         IRQ_TOGGLE: hit_w = valid_r && (cmp_i != state_r);
         default:    hit_w = 1'b1;
      endcase
   end

   // startup counter restarts every time the channel drops out
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt_r  <= '0;
         warm_r <= 1'b0;
         wup_r  <= 1'b0;
      end
      else
      begin
         wup_r <= reach_w;
         if (!enable_i)
         begin
            cnt_r  <= '0;
            warm_r <= 1'b0;
         end
         else if (reach_w)
            warm_r <= 1'b1;
         else if (!warm_r)
            cnt_r <= cnt_r + 1'b1;
      end
   end

   // sample store; a channel that drops out loses its valid sample
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         valid_r <= 1'b0;
         state_r <= 1'b0;
         irq_r   <= 1'b0;
      end
      else
      begin
         irq_r <= take_o && hit_w;
         if (!enable_i)
            valid_r <= 1'b0;
         else if (take_o)
         begin
            valid_r <= 1'b1;
            state_r <= cmp_i;
         end
      end
   end
endmodule
`default_nettype wire

// ---- cmpif_regs.sv ----
// Purpose: control, status, interrupt and test registers of the comparator interface
// Assumes: one-cycle strobes, read data registered one cycle after the read strobe
// Notes:   channel setup word holds the per-channel mode and irq choices, pair setup word the per-pair enable and irq choices
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01 - bypass bit set: channels see override register, else real comparators
// RULE_02 - in bypass, channel n takes override bit n
// RULE_03 - writing one to event launch starts a comparison; clears when done
// RULE_04 - an allowed peripheral event sets the event launch bit until done
// RULE_05 - writing one to software launch starts single measurement; clears when done
// RULE_06 - event trigger allow bit gates peripheral events
// RULE_07 - global enable off disables the whole interface
// RULE_08 - after enabling, a channel waits the startup interval before comparing
// RULE_09 - state bits 24..27 show pair input inside window
// RULE_10 - odd state bits show channel ready: valid, enabled, startup over
// RULE_11 - even state bits show current comparison result
// RULE_12 - mask-set write sets mask bits written one
// RULE_13 - mask-clear write clears mask bits written one
// RULE_14 - pending-clear write clears pending bits written one and their request
// RULE_15 - pair pending bits set on window-mode interrupt condition
// RULE_16 - startup pending bit set when startup elapses, held until cleared
// RULE_17 - channel pending bit set on comparison interrupt, held until cleared
// RULE_18 - presence bits 16..19 show which pairs exist
// RULE_19 - presence bits 0..7 show which channels exist
// RULE_20 - event starts all event-mode channels together, others unaffected
// RULE_21 - mode codes: off 00, continuous 01, user 10, event 11
// RULE_22 - interrupt request high when any pending bit is also masked in
// RULE_23 - reserved bits read zero and ignore writes
module cmpif_regs
   import cmpif_pkg::*;
#(
   parameter int NUM_CH   = 8,
   parameter int NUM_PAIR = 4
)
(
   input  wire logic                clk_sys_i,
   input  wire logic                sys_rst_i,
   input  wire logic [CMPIF_AW-1:0] addr_i,
   input  wire logic [31:0]         wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   input  wire logic [7:0]          cmp_out_i,
   input  wire logic                periph_evt_i,
   output logic [31:0]              rdata_o,
   output logic                     irq_o
);
   // a pair needs two channels; the layout has room for eight channels
   if (NUM_CH < 1 || NUM_CH > 8 || NUM_PAIR < 0 || 2 * NUM_PAIR > NUM_CH)
   begin : g_bad_cfg
      $error("cmpif_regs: channel or pair count out of range");
   end

   logic                   en_r;
   logic                   evt_allow_r;
   logic                   bypass_r;
   logic                   swgo_r;
   logic                   evgo_r;
   logic [CMPIF_WUP_W-1:0] wup_r;
   logic [7:0]             ovr_r;
   logic [15:0]            mode_r;
   logic [15:0]            chsel_r;
   logic [3:0]             wen_r;
   logic [7:0]             wsel_r;
   logic [31:0]            mask_r;
   logic [31:0]            pend_r;
   logic [31:0]            rdata_r;
   logic                   irq_r;
   logic [3:0]             inside_r;

   logic [7:0]             ch_present_w;
   logic [3:0]             pair_present_w;
   logic [31:0]            valid_w;
   logic [7:0]             cmp_sel_w;
   logic [7:0]             warm_w;
   logic [7:0]             take_w;
   logic [7:0]             ready_w;
   logic [7:0]             state_w;
   logic [7:0]             ch_irq_w;
   logic [7:0]             wup_irq_w;
   logic [7:0]             is_user_w;
   logic [7:0]             is_evt_w;
   logic [3:0]             inside_w;
   logic [3:0]             pair_irq_w;
   logic [31:0]            ev_w;
   logic [15:0]            state_word_w;
   logic                   user_done_w;
   logic                   evt_done_w;
   logic                   evt_in_w;

   // address decode
   logic wr_ctrl_w;
   logic wr_mset_w;
   logic wr_mclr_w;
   logic wr_pclr_w;
   logic wr_ovr_w;
   logic wr_chs_w;
   logic wr_prs_w;
   assign wr_ctrl_w = wr_i && (addr_i == OFS_CTRL);
   assign wr_mset_w = wr_i && (addr_i == OFS_MASK_SET);
   assign wr_mclr_w = wr_i && (addr_i == OFS_MASK_CLR);
   assign wr_pclr_w = wr_i && (addr_i == OFS_PEND_CLR);
   assign wr_ovr_w  = wr_i && (addr_i == OFS_OVERRIDE);
   assign wr_chs_w  = wr_i && (addr_i == OFS_CH_SETUP);
   assign wr_prs_w  = wr_i && (addr_i == OFS_PAIR_SETUP);

   // presence and the set of implemented interrupt bits
   assign ch_present_w   = 8'((9'h001 << NUM_CH) - 9'h001); // RULE_19
   assign pair_present_w = 4'((5'h01 << NUM_PAIR) - 5'h01); // RULE_18

   // choose real or override comparator levels
   assign cmp_sel_w = bypass_r ? ovr_r : cmp_out_i; // RULE_01 RULE_02

   // peripheral event only counts while allowed and enabled
   assign evt_in_w = periph_evt_i && evt_allow_r && en_r; // RULE_06 RULE_07

   // a launch ends once every channel in its mode has had its sample
   assign user_done_w = !en_r || ((is_user_w & ~warm_w) == 8'h00);
   assign evt_done_w  = !en_r || ((is_evt_w & ~warm_w) == 8'h00);

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_ch
         if (gi < NUM_CH)
         begin : g_on
            logic [1:0] m_w;
            assign m_w = mode_r[2*gi+1:2*gi]; // RULE_21
            assign is_user_w[gi] = en_r && (m_w == MODE_USER);
            assign is_evt_w[gi]  = en_r && (m_w == MODE_EVENT);
            cmpif_chan u_chan (
               .clk_sys_i  (clk_sys_i),
               .sys_rst_i  (sys_rst_i),
               .enable_i   (en_r && (m_w != MODE_OFF)), // RULE_07
               .mode_i     (m_w),
               .irq_sel_i  (chsel_r[2*gi+1:2*gi]),
               .startup_i  (wup_r), // RULE_08
               .cmp_i      (cmp_sel_w[gi]),
               .user_go_i  (swgo_r),
               .event_go_i (evgo_r), // RULE_20
               .warm_o     (warm_w[gi]),
               .take_o     (take_w[gi]),
               .ready_o    (ready_w[gi]),
               .state_o    (state_w[gi]),
               .irq_o      (ch_irq_w[gi]),
               .wup_done_o (wup_irq_w[gi])
            );
         end
         else
         begin : g_off
            assign is_user_w[gi] = 1'b0;
            assign is_evt_w[gi]  = 1'b0;
            assign warm_w[gi]    = 1'b0;
            assign take_w[gi]    = 1'b0;
            assign ready_w[gi]   = 1'b0;
            assign state_w[gi]   = 1'b0;
            assign ch_irq_w[gi]  = 1'b0;
            assign wup_irq_w[gi] = 1'b0;
         end
         // ready on odd, comparison on even positions
         assign state_word_w[2*gi]   = state_w[gi] && ready_w[gi]; // RULE_11
         assign state_word_w[2*gi+1] = ready_w[gi]; // RULE_10
         assign ev_w[2*gi]   = ch_irq_w[gi]; // RULE_17
         assign ev_w[2*gi+1] = wup_irq_w[gi]; // RULE_16
      end

      // window pairs: even channel high below upper, odd high above lower
      for (gi = 0; gi < 4; gi++)
      begin : g_pair
         logic wdone_w;
         assign inside_w[gi] = pair_present_w[gi] &&
                               ready_w[2*gi] && ready_w[2*gi+1] &&
                               state_w[2*gi] && state_w[2*gi+1];
         assign wdone_w = take_w[2*gi] && take_w[2*gi+1];
         always_comb
         begin
            case (wsel_r[2*gi+1:2*gi])
               IRQ_HIGH:   pair_irq_w[gi] = inside_w[gi] && !inside_r[gi];
               IRQ_LOW:    pair_irq_w[gi] = !inside_w[gi] && inside_r[gi];
               IRQ_TOGGLE: pair_irq_w[gi] = inside_w[gi] != inside_r[gi];
               default:    pair_irq_w[gi] = wdone_w;
            endcase
         end
         assign ev_w[PAIR_LSB+gi] = wen_r[gi] && pair_present_w[gi] &&
                                    pair_irq_w[gi]; // RULE_15
      end
   endgenerate
   assign ev_w[23:16] = 8'h00;
   assign ev_w[31:28] = 4'h0;

   // only implemented bits can hold a mask or pending state
   assign valid_w = {4'h0, pair_present_w, 8'h00,
                     {ch_present_w[7], ch_present_w[7]}, {ch_present_w[6], ch_present_w[6]},
                     {ch_present_w[5], ch_present_w[5]}, {ch_present_w[4], ch_present_w[4]},
                     {ch_present_w[3], ch_present_w[3]}, {ch_present_w[2], ch_present_w[2]},
                     {ch_present_w[1], ch_present_w[1]}, {ch_present_w[0], ch_present_w[0]}};

   // control word; launch bits are set by a one and cleared by completion
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         en_r        <= 1'b0;
         evt_allow_r <= 1'b0;
         bypass_r    <= 1'b0;
         wup_r       <= RST_WUP;
         swgo_r      <= 1'b0;
         evgo_r      <= 1'b0;
      end
      else
      begin
         if (wr_ctrl_w)
         begin
            en_r        <= wdata_i[CTRL_EN_BIT]; // RULE_07
            evt_allow_r <= wdata_i[CTRL_EVT_BIT]; // RULE_06
            bypass_r    <= wdata_i[CTRL_BYPASS_BIT]; // RULE_01
            wup_r       <= wdata_i[CTRL_WUP_LSB+CMPIF_WUP_W-1:CTRL_WUP_LSB];
         end
         // a fresh one wins over completion in the same cycle
         swgo_r <= (swgo_r && !user_done_w) ||
                   (wr_ctrl_w && wdata_i[CTRL_SWGO_BIT]); // RULE_05
         evgo_r <= (evgo_r && !evt_done_w) ||
                   (wr_ctrl_w && wdata_i[CTRL_EVGO_BIT]) || // RULE_03
                   evt_in_w; // RULE_04
      end
   end

   // setup words and override value
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ovr_r   <= RST_BYTE;
         mode_r  <= RST_WORD[15:0];
         chsel_r <= RST_WORD[15:0];
         wen_r   <= RST_WORD[3:0];
         wsel_r  <= RST_BYTE;
      end
      else
      begin
         if (wr_ovr_w)
            ovr_r <= wdata_i[7:0]; // RULE_02
         if (wr_chs_w)
         begin
            mode_r  <= wdata_i[15:0];
            chsel_r <= wdata_i[SETUP_IRQ_LSB+15:SETUP_IRQ_LSB];
         end
         if (wr_prs_w)
         begin
            wen_r  <= wdata_i[3:0];
            wsel_r <= wdata_i[PSETUP_IRQ_LSB+7:PSETUP_IRQ_LSB];
         end
      end
   end

   // mask and pending; a new event wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         mask_r   <= RST_WORD;
         pend_r   <= RST_WORD;
         inside_r <= RST_WORD[3:0];
         irq_r    <= 1'b0;
      end
      else
      begin
         inside_r <= inside_w;
         if (wr_mset_w)
            mask_r <= mask_r | (wdata_i & valid_w); // RULE_12 RULE_23
         else if (wr_mclr_w)
            mask_r <= mask_r & ~wdata_i; // RULE_13
         pend_r <= ((pend_r & ~(wr_pclr_w ? wdata_i : 32'h0000_0000)) |
                    ev_w) & valid_w; // RULE_14
         irq_r  <= |(pend_r & mask_r); // RULE_22
      end
   end

   // read mux, registered; unmapped and write-only offsets read zero
   logic [31:0] rmux_w;
   always_comb
   begin
      case (addr_i)
         OFS_CTRL:       rmux_w = {14'h0000, wup_r, bypass_r, 1'b0, evgo_r,
                                   swgo_r, 2'h0, evt_allow_r, en_r};
         OFS_STATE:      rmux_w = {4'h0, inside_w, 8'h00, state_word_w}; // RULE_09
         OFS_MASK_VIEW:  rmux_w = mask_r;
         OFS_PEND:       rmux_w = pend_r;
         OFS_OVERRIDE:   rmux_w = {24'h00_0000, ovr_r}; // RULE_23
         OFS_PRESENCE:   rmux_w = {12'h000, pair_present_w, 8'h00, ch_present_w};
         OFS_CH_SETUP:   rmux_w = {chsel_r, mode_r};
         OFS_PAIR_SETUP: rmux_w = {20'h0_0000, wsel_r, wen_r};
         default:        rmux_w = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rdata_r <= RST_WORD;
      else
         rdata_r <= rd_i ? rmux_w : 32'h0000_0000;
   end

   assign rdata_o = rdata_r;
   assign irq_o   = irq_r;

   // checks
   sequence s_user_write;
      wr_ctrl_w && wdata_i[CTRL_SWGO_BIT];
   endsequence
   sequence s_user_end;
      swgo_r && user_done_w && !wr_ctrl_w;
   endsequence

   property p_override;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (bypass_r && take_w[0]) |=> (state_w[0] == $past(ovr_r[0]));
   endproperty
   a_override: assert property (p_override) // RULE_02
      else $error("channel 0 did not take override value");

   property p_real;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!bypass_r && take_w[0]) |=> (state_w[0] == $past(cmp_out_i[0]));
   endproperty
   a_real: assert property (p_real) // RULE_01
      else $error("channel 0 did not take comparator level");

   property p_user_set;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_user_write |=> swgo_r;
   endproperty
   a_user_set: assert property (p_user_set) // RULE_05
      else $error("software launch bit not set");

   property p_user_clear;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_user_end |=> !swgo_r;
   endproperty
   a_user_clear: assert property (p_user_clear) // RULE_05
      else $error("software launch bit not cleared when done");

   property p_evt_set;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (periph_evt_i && evt_allow_r && en_r) |=> evgo_r;
   endproperty
   a_evt_set: assert property (p_evt_set) // RULE_04
      else $error("event launch bit not set by event");

   property p_evt_gate;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!evgo_r && !evt_allow_r && !wr_ctrl_w) |=> !evgo_r;
   endproperty
   a_evt_gate: assert property (p_evt_gate) // RULE_06
      else $error("event launch set while events not allowed");

   property p_ready;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      ready_w[0] |-> (en_r && warm_w[0] && mode_r[1:0] != MODE_OFF);
   endproperty
   a_ready: assert property (p_ready) // RULE_10
      else $error("channel 0 ready without enable or startup");

   property p_mask;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (wr_mset_w && wdata_i[1]) |=> mask_r[1] ##1 (mask_r[1] || $past(wr_mclr_w));
   endproperty
   a_mask: assert property (p_mask) // RULE_12
      else $error("mask bit not set by mask-set write");

   property p_pclear;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (wr_pclr_w && wdata_i[1] && !ev_w[1]) |=> !pend_r[1];
   endproperty
   a_pclear: assert property (p_pclear) // RULE_14
      else $error("pending bit not cleared");

   property p_wup;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      wup_irq_w[0] |=> pend_r[1];
   endproperty
   a_wup: assert property (p_wup) // RULE_16
      else $error("startup pending not set");

   property p_irq;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (|(pend_r & mask_r)) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) // RULE_22
      else $error("interrupt request missing");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench for the comparator interface register block
// Assumes: bench drives every port itself; design assertions run alongside
// Notes:   expected words are built from the register map, never from the design
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import cmpif_pkg::*;
;
   logic        clk_sys_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [7:0]  addr_i    = 8'h00;
   logic [31:0] wdata_i   = 32'h0000_0000;
   logic        wr_i      = 1'b0;
   logic        rd_i      = 1'b0;
   logic [7:0]  cmp_i     = 8'h00;
   logic        evt_i     = 1'b0;
   logic [31:0] rdata_o;
   logic        irq_o;
   int          errors    = 0;
   int          checked   = 0;

   // 250 MHz system clock
   always #2 clk_sys_i = ~clk_sys_i;

   cmpif_regs i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .cmp_out_i(cmp_i),
      .periph_evt_i(evt_i), .rdata_o(rdata_o), .irq_o(irq_o));

   // closing report, shared by the main sequence and the watchdog
   task automatic conclude();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk_sys_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i   <= 1'b0;
      @(negedge clk_sys_i);
      chk(rdata_o & m, e);
      // hand back on a rising edge so callers drive inputs there
      @(posedge clk_sys_i);
   endtask

   // bounded wait on the interrupt level; running out counts as a mismatch
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      @(negedge clk_sys_i);
      while (irq_o !== v && n < 16)
      begin
         @(negedge clk_sys_i);
         n++;
      end
      chk({31'h0, irq_o}, {31'h0, v});
      if (irq_o !== v)
         conclude();
      @(posedge clk_sys_i);
   endtask

   task automatic evt();
      @(posedge clk_sys_i);
      evt_i <= 1'b1;
      @(posedge clk_sys_i);
      evt_i <= 1'b0;
   endtask

   // state word when every channel is ready with comparator levels c
   function automatic logic [31:0] st(input logic [7:0] c);
      logic [31:0] s;
      s = 32'h0000_0000;
      for (int n = 0; n < 8; n++)
      begin
         s[2*n]   = c[n];
         s[2*n+1] = 1'b1;
      end
      for (int p = 0; p < 4; p++)
         s[24+p] = c[2*p] & c[2*p+1];
      return s;
   endfunction

   task automatic t_reset();
      logic [7:0] a [7] = '{OFS_CTRL, OFS_STATE, OFS_MASK_SET, OFS_MASK_VIEW, OFS_PEND,
                            OFS_OVERRIDE, 8'h3C};
      for (int i = 0; i < 7; i++)
         rd_chk(a[i], 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk(OFS_PRESENCE, 32'hFFFF_FFFF, 32'h000F_00FF);
      chk({31'h0, irq_o}, 32'h0000_0000);
   endtask

   task automatic t_mask();
      wr(OFS_MASK_SET, 32'hFFFF_FFFF);
      rd_chk(OFS_MASK_VIEW, 32'hFFFF_FFFF, 32'h0F00_FFFF);
      wr(OFS_MASK_CLR, 32'h0000_00F0);
      rd_chk(OFS_MASK_VIEW, 32'hFFFF_FFFF, 32'h0F00_FF0F);
      wr(OFS_MASK_CLR, 32'hFFFF_FFFF);
      rd_chk(OFS_MASK_VIEW, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(OFS_OVERRIDE, 32'hFFFF_FFA5);
      rd_chk(OFS_OVERRIDE, 32'hFFFF_FFFF, 32'h0000_00A5);
      wr(OFS_PRESENCE, 32'h0000_0000);
      rd_chk(OFS_PRESENCE, 32'hFFFF_FFFF, 32'h000F_00FF);
   endtask

   // continuous channels, bypass on then off, windows and pending flow
   task automatic t_cont();
      wr(OFS_CH_SETUP, 32'h0000_5555);
      wr(OFS_PAIR_SETUP, 32'h0000_000F);
      wr(OFS_OVERRIDE, 32'h0000_003C);
      cmp_i <= 8'hC3;
      wr(OFS_CTRL, 32'h0000_0381);
      cyc(12);
      rd_chk(OFS_STATE, 32'hFFFF_FFFF, st(8'h3C));
      wr(OFS_CTRL, 32'h0000_0301);
      cyc(4);
      rd_chk(OFS_STATE, 32'hFFFF_FFFF, st(8'hC3));
      rd_chk(OFS_PEND, 32'h0F00_AAAA, 32'h0F00_AAAA);
      cmp_i <= 8'h00;
      cyc(3);
      wr(OFS_PEND_CLR, 32'hFFFF_FFFF);
      rd_chk(OFS_PEND, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(OFS_MASK_SET, 32'h0000_0001);
      wait_irq(1'b0);
      cmp_i <= 8'h01;
      wait_irq(1'b1);
      rd_chk(OFS_PEND, 32'h0000_0001, 32'h0000_0001);
      cmp_i <= 8'h00;
      wr(OFS_PEND_CLR, 32'h0000_0001);
      wait_irq(1'b0);
      wr(OFS_CTRL, 32'h0000_0000);
      cyc(3);
      rd_chk(OFS_STATE, 32'hFFFF_FFFF, 32'h0000_0000);
   endtask

   // long startup interval holds the ready bits off
   task automatic t_startup();
      wr(OFS_CTRL, 32'h0000_1401);
      cyc(5);
      rd_chk(OFS_STATE, 32'h0000_AAAA, 32'h0000_0000);
      cyc(25);
      rd_chk(OFS_STATE, 32'h0000_AAAA, 32'h0000_AAAA);
   endtask

   task automatic t_user();
      wr(OFS_PAIR_SETUP, 32'h0000_0000);
      wr(OFS_CH_SETUP, 32'h0000_AAAA);
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0001);
      cmp_i <= 8'h0F;
      cyc(4);
      wr(OFS_CTRL, 32'h0000_0011);
      cyc(6);
      rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
      rd_chk(OFS_STATE, 32'h0000_FFFF, st(8'h0F) & 32'h0000_FFFF);
   endtask

   // event-mode channels 0..3 beside user-mode channels 4..7
   task automatic t_event();
      wr(OFS_CH_SETUP, 32'h0000_AAFF);
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0001);
      cmp_i <= 8'hFF;
      cyc(4);
      evt();
      cyc(6);
      rd_chk(OFS_STATE, 32'h0000_FFFF, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0003);
      evt();
      cyc(6);
      rd_chk(OFS_STATE, 32'h0000_FFFF, 32'h0000_00FF);
      rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0003);
      cmp_i <= 8'h05;
      wr(OFS_CTRL, 32'h0000_0023);
      cyc(6);
      rd_chk(OFS_STATE, 32'h0000_FFFF, 32'h0000_00BB);
      rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0003);
   endtask

   // low and toggle selections on channels 0 and 1, leave selection on pair 0
   task automatic t_sel();
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_CH_SETUP, 32'h0009_0005);
      wr(OFS_PAIR_SETUP, 32'h0000_0011);
      cmp_i <= 8'h03;
      wr(OFS_CTRL, 32'h0000_0001);
      cyc(4);
      wr(OFS_PEND_CLR, 32'hFFFF_FFFF);
      rd_chk(OFS_PEND, 32'h0100_000F, 32'h0000_0000);
      cmp_i <= 8'h00;
      cyc(4);
      rd_chk(OFS_PEND, 32'h0100_000F, 32'h0100_0005);
   endtask

   // main sequence: reset for four cycles, then each scenario in turn
   initial
   begin
      cyc(4);
      sys_rst_i <= 1'b0;
      t_reset();
      t_mask();
      t_cont();
      t_startup();
      t_user();
      t_event();
      t_sel();
      conclude();
   end

   // watchdog against a hung run
   initial
   begin
      cyc(20000);
      errors++;
      conclude();
   end
endmodule
`default_nettype wire
